// File: core/pac_pkg.sv
// Constants, field layout and types for the pulse accumulator control block
//------------------------------------------------------------------------------
// Summary of operation
// RULE1 - Accumulator enable bit 6 works independently of the timer enable
// RULE2 - Accumulator input is the channel 7 pin, shared with the timer channel
// RULE3 - Mode bit 5: 0 event counting, 1 gated time; only while enabled
// RULE4 - Event mode counts falling edges with edge bit 4 clear, rising when set
// RULE5 - Gated, edge 0: high level gates div-64 tick; trailing fall sets edge flag
// RULE6 - Gated, edge 1: low level gates div-64 tick; trailing rise sets edge flag
// RULE7 - Timer disabled means no div-64 tick, so gated counting stalls
// RULE8 - Clock select bits 3:2 pick prescaler, accum clock, clock/256, clock/65536
// RULE9 - Accumulator disabled forces the prescaler as timer counter clock
// RULE10 - New clock select takes effect at once after the write
// RULE11 - Overflow interrupt enable bit 1 requests interrupt while overflow flag set
// RULE12 - Input interrupt enable bit 0 requests interrupt while edge flag set
// RULE13 - With fast clear on, any count register access clears all flags
// RULE14 - Flag clears need timer or accumulator enabled; otherwise ignored
// RULE15 - Control register reads and writes are always allowed
// RULE16 - Overflow flag bit 1 sets when count wraps from ffff to 0000
// RULE17 - Writing one to a flag bit clears it while timer or accumulator enabled
// RULE18 - Pin is synchronised to the bus clock before counting
// RULE19 - Only flag bits 1 and 0 exist; others read zero, ignore writes
//------------------------------------------------------------------------------
`default_nettype none
package pac_pkg;

   //---------------------------------------------------------------------------
   // Register indices and byte addresses
   //---------------------------------------------------------------------------
   localparam int           PAC_ADDR_W       = 10;
   localparam logic [7:0]   PAC_IDX_CONTROL  = 8'h20;
   localparam logic [7:0]   PAC_IDX_FLAGS    = 8'h21;
   localparam logic [7:0]   PAC_IDX_COUNT    = 8'h22;
   localparam logic [7:0]   PAC_IDX_SYSCTL   = 8'h26;
   localparam logic [9:0]   PAC_ADDR_CONTROL = {PAC_IDX_CONTROL, 2'b00};
   localparam logic [9:0]   PAC_ADDR_FLAGS   = {PAC_IDX_FLAGS, 2'b00};
   localparam logic [9:0]   PAC_ADDR_COUNT   = {PAC_IDX_COUNT, 2'b00};
   localparam logic [9:0]   PAC_ADDR_SYSCTL  = {PAC_IDX_SYSCTL, 2'b00};

   //---------------------------------------------------------------------------
   // Field positions
   //---------------------------------------------------------------------------
   localparam int           PAC_CTL_ENABLE   = 6;
   localparam int           PAC_CTL_MODE     = 5;
   localparam int           PAC_CTL_EDGE     = 4;
   localparam int           PAC_CTL_CLK_HI   = 3;
   localparam int           PAC_CTL_CLK_LO   = 2;
   localparam int           PAC_CTL_OVI      = 1;
   localparam int           PAC_CTL_II       = 0;
   localparam int           PAC_CTL_W        = 7;
   localparam int           PAC_FLG_OVF      = 1;
   localparam int           PAC_FLG_EDGE     = 0;
   localparam int           PAC_FLG_W        = 2;
   localparam int           PAC_SYS_TEN      = 0;
   localparam int           PAC_SYS_FFCA     = 1;
   localparam int           PAC_SYS_W        = 2;

   //---------------------------------------------------------------------------
   // Reset values and counts
   //---------------------------------------------------------------------------
   localparam logic [6:0]   PAC_CTL_RESET    = 7'h00;
   localparam logic [1:0]   PAC_FLG_RESET    = 2'h0;
   localparam logic [1:0]   PAC_SYS_RESET    = 2'h0;
   localparam int           PAC_COUNT_W      = 16;
   localparam logic [15:0]  PAC_COUNT_RESET  = 16'h0000;
   localparam logic [15:0]  PAC_COUNT_MAX    = 16'hffff;
   localparam logic [7:0]   PAC_LOW_MAX      = 8'hff;
   localparam int           PAC_GATE_DIV     = 64;
   localparam int           PAC_GATE_W       = $clog2(PAC_GATE_DIV);
   localparam logic [5:0]   PAC_GATE_LAST    = 6'(PAC_GATE_DIV - 1);
   localparam logic [5:0]   PAC_GATE_RESET   = 6'h00;

   //---------------------------------------------------------------------------
   // Timer counter clock choices
   //---------------------------------------------------------------------------
   typedef enum logic [1:0] {
      PAC_CLK_PRESCALER = 2'b00,
      PAC_CLK_ACCUM     = 2'b01,
      PAC_CLK_DIV256    = 2'b10,
      PAC_CLK_DIV65536  = 2'b11
   } pac_clksel_type;

endpackage
`default_nettype wire

// File: core/pac_pin_sync.sv
// Two-stage synchroniser and edge detector for the channel 7 pin
`timescale 1ns/1ps
`default_nettype none
module pac_pin_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pin_async,
   output logic      pin_level,
   output logic      pin_rise,
   output logic      pin_fall
);

   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   //---------------------------------------------------------------------------
   // Synchroniser and history
   //---------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= pin_async;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign pin_level = sync_reg;
   assign pin_rise  = sync_reg & ~last_reg;
   assign pin_fall  = ~sync_reg & last_reg;

endmodule // pac_pin_sync
`default_nettype wire

// File: core/pac_accum_control.sv
// Pulse accumulator control, flags, count and timer clock select with APB
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pac_accum_control (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [pac_pkg::PAC_ADDR_W-1:0] paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic                          channel7_pin,
   input  wire logic                          prescaler_tick,
   output logic                               timer_clock_tick,
   output logic                               accum_edge_clock,
   output logic                               overflow_irq,
   output logic                               input_irq
);

   //---------------------------------------------------------------------------
   // Storage
   //---------------------------------------------------------------------------
   logic [pac_pkg::PAC_CTL_W-1:0]   accum_control_reg;
   logic [pac_pkg::PAC_CTL_W-1:0]   accum_control_next;
   logic [pac_pkg::PAC_FLG_W-1:0]   accum_flags_reg;
   logic [pac_pkg::PAC_FLG_W-1:0]   accum_flags_next;
   logic [pac_pkg::PAC_SYS_W-1:0]   sysctl_reg;
   logic [pac_pkg::PAC_SYS_W-1:0]   sysctl_next;
   logic [pac_pkg::PAC_COUNT_W-1:0] accum_count_reg;
   logic [pac_pkg::PAC_COUNT_W-1:0] accum_count_next;
   logic [pac_pkg::PAC_GATE_W-1:0]  gate_div_reg;
   logic [pac_pkg::PAC_GATE_W-1:0]  gate_div_next;
   logic [31:0]                     prdata_reg;
   logic [31:0]                     prdata_next;
   logic                            timer_tick_reg;
   logic                            timer_tick_next;
   logic                            edge_clock_reg;

   //---------------------------------------------------------------------------
   // Bus decode
   //---------------------------------------------------------------------------
   wire logic setup_phase;
   wire logic access_phase;
   wire logic sel_control;
   wire logic sel_flags;
   wire logic sel_count;
   wire logic sel_sysctl;
   wire logic sel_mapped;
   wire logic wr_control;
   wire logic wr_flags;
   wire logic wr_count;
   wire logic wr_sysctl;

   assign setup_phase  = psel & ~penable;
   assign access_phase = psel & penable;
   assign sel_control  = (paddr == pac_pkg::PAC_ADDR_CONTROL);
   assign sel_flags    = (paddr == pac_pkg::PAC_ADDR_FLAGS);
   assign sel_count    = (paddr == pac_pkg::PAC_ADDR_COUNT);
   assign sel_sysctl   = (paddr == pac_pkg::PAC_ADDR_SYSCTL);
   assign sel_mapped   = sel_control | sel_flags | sel_count | sel_sysctl;
   assign wr_control   = access_phase & pwrite & sel_control; // RULE15
   assign wr_flags     = access_phase & pwrite & sel_flags;
   assign wr_count     = access_phase & pwrite & sel_count;
   assign wr_sysctl    = access_phase & pwrite & sel_sysctl;

   assign pready  = 1'b1;
   assign pslverr = access_phase & ~sel_mapped;
   assign prdata  = prdata_reg;

   //---------------------------------------------------------------------------
   // Control fields
   //---------------------------------------------------------------------------
   wire logic                    accum_enable;
   wire logic                    accum_mode;
   wire logic                    accum_edge_select;
   wire pac_pkg::pac_clksel_type clock_select;
   wire logic                    overflow_irq_enable;
   wire logic                    input_irq_enable;
   wire logic                    timer_enable;
   wire logic                    fast_flag_clear_all;

   assign accum_enable        = accum_control_reg[pac_pkg::PAC_CTL_ENABLE]; // RULE1
   assign accum_mode          = accum_control_reg[pac_pkg::PAC_CTL_MODE];
   assign accum_edge_select   = accum_control_reg[pac_pkg::PAC_CTL_EDGE];
   assign clock_select        = pac_pkg::pac_clksel_type'(
      accum_control_reg[pac_pkg::PAC_CTL_CLK_HI:pac_pkg::PAC_CTL_CLK_LO]);
   assign overflow_irq_enable = accum_control_reg[pac_pkg::PAC_CTL_OVI];
   assign input_irq_enable    = accum_control_reg[pac_pkg::PAC_CTL_II];
   assign timer_enable        = sysctl_reg[pac_pkg::PAC_SYS_TEN];
   assign fast_flag_clear_all = sysctl_reg[pac_pkg::PAC_SYS_FFCA];

   assign accum_control_next = wr_control ? pwdata[pac_pkg::PAC_CTL_W-1:0]
                                          : accum_control_reg;
   assign sysctl_next        = wr_sysctl ? pwdata[pac_pkg::PAC_SYS_W-1:0]
                                         : sysctl_reg;

   //---------------------------------------------------------------------------
   // Pin input
   //---------------------------------------------------------------------------
   wire logic pin_level;
   wire logic pin_rise;
   wire logic pin_fall;

   pac_pin_sync u_pin_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin_async (channel7_pin), // RULE2
      .pin_level (pin_level),
      .pin_rise  (pin_rise),
      .pin_fall  (pin_fall)
   ); // RULE18

   //---------------------------------------------------------------------------
   // Divide-by-64 tick, only while the timer runs
   //---------------------------------------------------------------------------
   wire logic gate_tick;

   assign gate_div_next = timer_enable
                          ? pac_pkg::PAC_GATE_W'(gate_div_reg + 1'b1)
                          : pac_pkg::PAC_GATE_RESET; // RULE7
   assign gate_tick     = timer_enable & (gate_div_reg == pac_pkg::PAC_GATE_LAST); // RULE7

   //---------------------------------------------------------------------------
   // Accumulator clock and count
   //---------------------------------------------------------------------------
   wire logic selected_edge;
   wire logic gate_open;
   wire logic accum_clock;
   wire logic count_at_max;
   wire logic count_wrap;
   wire logic div256_tick;
   wire logic edge_event;

   // Falling edge by default, rising with edge select set; in gated mode the
   // same edge is the trailing end of the gate
   assign selected_edge = accum_edge_select ? pin_rise : pin_fall; // RULE4
   assign gate_open     = accum_edge_select ? ~pin_level : pin_level; // RULE5 RULE6
   assign accum_clock   = accum_enable & (accum_mode ? (gate_open & gate_tick)
                                                     : selected_edge); // RULE3
   assign edge_event    = accum_enable & selected_edge; // RULE5 RULE6
   assign count_at_max  = (accum_count_reg == pac_pkg::PAC_COUNT_MAX);
   assign count_wrap    = accum_clock & ~wr_count & count_at_max; // RULE16
   assign div256_tick   = accum_clock & ~wr_count
                          & (accum_count_reg[7:0] == pac_pkg::PAC_LOW_MAX);

   // Software load wins over a count in the same cycle
   assign accum_count_next = wr_count ? pwdata[pac_pkg::PAC_COUNT_W-1:0]
                           : accum_clock
                             ? pac_pkg::PAC_COUNT_W'(accum_count_reg + 1'b1)
                             : accum_count_reg;

   //---------------------------------------------------------------------------
   // Flags: a hardware set wins over any clear
   //---------------------------------------------------------------------------
   wire logic                          clear_allowed;
   wire logic                          fast_clear;
   wire logic [pac_pkg::PAC_FLG_W-1:0] flag_set;
   wire logic [pac_pkg::PAC_FLG_W-1:0] flag_clear;

   assign clear_allowed = timer_enable | accum_enable; // RULE14
   assign fast_clear    = access_phase & sel_count & fast_flag_clear_all; // RULE13
   assign flag_set      = {count_wrap, edge_event};
   assign flag_clear    = clear_allowed
                          ? ((wr_flags ? pwdata[pac_pkg::PAC_FLG_W-1:0]
                                       : pac_pkg::PAC_FLG_RESET) // RULE17
                             | {pac_pkg::PAC_FLG_W{fast_clear}}) // RULE13
                          : pac_pkg::PAC_FLG_RESET; // RULE14
   assign accum_flags_next = (accum_flags_reg & ~flag_clear) | flag_set;

   //---------------------------------------------------------------------------
   // Timer counter clock select
   //---------------------------------------------------------------------------
   logic selected_clock;

   always_comb begin
      unique case (clock_select) // RULE8
         pac_pkg::PAC_CLK_PRESCALER: selected_clock = prescaler_tick;
         pac_pkg::PAC_CLK_ACCUM:     selected_clock = accum_clock;
         pac_pkg::PAC_CLK_DIV256:    selected_clock = div256_tick;
         pac_pkg::PAC_CLK_DIV65536:  selected_clock = count_wrap;
      endcase
   end

   // Selection follows the register directly, no boundary wait
   assign timer_tick_next = accum_enable ? selected_clock // RULE10
                                         : prescaler_tick; // RULE9

   //---------------------------------------------------------------------------
   // Read data, captured in the setup phase
   //---------------------------------------------------------------------------
   wire logic [31:0] rd_control;
   wire logic [31:0] rd_flags;
   wire logic [31:0] rd_count;
   wire logic [31:0] rd_sysctl;

   assign rd_control  = 32'(accum_control_reg);
   assign rd_flags    = 32'(accum_flags_reg); // RULE19
   assign rd_count    = 32'(accum_count_reg);
   assign rd_sysctl   = 32'(sysctl_reg);
   assign prdata_next = !(setup_phase & ~pwrite) ? prdata_reg
                      : sel_control ? rd_control
                      : sel_flags   ? rd_flags
                      : sel_count   ? rd_count
                      : sel_sysctl  ? rd_sysctl
                      : 32'h0000_0000;

   //---------------------------------------------------------------------------
   // Interrupt requests
   //---------------------------------------------------------------------------
   assign overflow_irq = overflow_irq_enable
                         & accum_flags_reg[pac_pkg::PAC_FLG_OVF]; // RULE11
   assign input_irq    = input_irq_enable
                         & accum_flags_reg[pac_pkg::PAC_FLG_EDGE]; // RULE12

   assign timer_clock_tick = timer_tick_reg;
   assign accum_edge_clock = edge_clock_reg;

   //---------------------------------------------------------------------------
   // Registers
   //---------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accum_control_reg <= pac_pkg::PAC_CTL_RESET;
         accum_flags_reg   <= pac_pkg::PAC_FLG_RESET;
         sysctl_reg        <= pac_pkg::PAC_SYS_RESET;
         accum_count_reg   <= pac_pkg::PAC_COUNT_RESET;
         gate_div_reg      <= pac_pkg::PAC_GATE_RESET;
         prdata_reg        <= 32'h0000_0000;
         timer_tick_reg    <= 1'b0;
         edge_clock_reg    <= 1'b0;
      end else begin
         accum_control_reg <= accum_control_next;
         accum_flags_reg   <= accum_flags_next;
         sysctl_reg        <= sysctl_next;
         accum_count_reg   <= accum_count_next;
         gate_div_reg      <= gate_div_next;
         prdata_reg        <= prdata_next;
         timer_tick_reg    <= timer_tick_next;
         edge_clock_reg    <= accum_clock;
      end
   end

endmodule // pac_accum_control
`default_nettype wire

// File: tb/pac_accum_control_properties.sv
// Port-level assertions for the pulse accumulator control block
`timescale 1ns/1ps
`default_nettype none
module pac_accum_control_properties (
   input wire logic                            pclk,
   input wire logic                            presetn,
   input wire logic                            psel,
   input wire logic                            penable,
   input wire logic                            pwrite,
   input wire logic [pac_pkg::PAC_ADDR_W-1:0] paddr,
   input wire logic [31:0]                     pwdata,
   input wire logic [31:0]                     prdata,
   input wire logic                            prescaler_tick,
   input wire logic                            timer_clock_tick,
   input wire logic                            accum_edge_clock,
   input wire logic                            overflow_irq,
   input wire logic                            input_irq
);
   logic [6:0] ctl_reg;
   logic [1:0] sys_reg;
   wire logic  acc_w  = psel && penable && pwrite;
   wire logic  acc_r  = psel && penable && !pwrite;
   // Shadow copies of control and system bits, taken from completed writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_reg <= 7'h00;
         sys_reg <= 2'h0;
      end else begin
         if (acc_w && paddr == pac_pkg::PAC_ADDR_CONTROL) ctl_reg <= pwdata[6:0];
         if (acc_w && paddr == pac_pkg::PAC_ADDR_SYSCTL) sys_reg <= pwdata[1:0];
      end
   end
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   prescaler_forced_a: assert property (
      !ctl_reg[6] && $past(!ctl_reg[6]) |-> timer_clock_tick == $past(prescaler_tick))
      else $error("timer tick not from prescaler while accumulator off");
   accum_select_a: assert property (
      $past(ctl_reg[6]) && $past(ctl_reg[3:2]) == 2'b01 |-> timer_clock_tick == accum_edge_clock)
      else $error("timer tick differs from accumulator clock");
   ovf_irq_gate_a: assert property (!ctl_reg[1] |-> !overflow_irq)
      else $error("overflow request while its enable is clear");
   in_irq_gate_a: assert property (input_irq |-> ctl_reg[0])
      else $error("input request while its enable is clear");
   count_enable_a: assert property (accum_edge_clock |-> $past(ctl_reg[6]))
      else $error("accumulator advanced while disabled");
   gated_stall_a: assert property (
      accum_edge_clock && $past(ctl_reg[5]) |-> $past(sys_reg[0]))
      else $error("gated count advanced with timer off");
   flag_upper_a: assert property (
      acc_r && paddr == pac_pkg::PAC_ADDR_FLAGS |-> prdata[31:2] == 30'h0)
      else $error("unused flag bits read nonzero");
   ctl_readback_a: assert property (
      acc_r && paddr == pac_pkg::PAC_ADDR_CONTROL |-> prdata == {25'h0, ctl_reg})
      else $error("control readback differs from last write");
endmodule // pac_accum_control_properties
bind pac_accum_control pac_accum_control_properties u_pac_accum_control_properties (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .prescaler_tick(prescaler_tick),
   .timer_clock_tick(timer_clock_tick), .accum_edge_clock(accum_edge_clock),
   .overflow_irq(overflow_irq), .input_irq(input_irq));
`default_nettype wire

// File: tb/pac_pin_source.sv
// Model of the pulse or gate source on the channel 7 pin
`timescale 1ns/1ps
`default_nettype none
module pac_pin_source (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        idle_level,
   input  wire logic        start,
   input  wire logic [7:0]  pulses,
   input  wire logic [11:0] width,
   output logic             channel7_pin,
   output logic             busy
);
   logic [7:0]  left_reg;
   logic [11:0] cnt_reg;
   logic        act_reg;
   assign channel7_pin = act_reg ? ~idle_level : idle_level;
   assign busy = left_reg != 8'h00;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left_reg <= 8'h00;
         cnt_reg  <= 12'h000;
         act_reg  <= 1'b0;
      end else if (start && !busy) begin
         left_reg <= pulses;
         cnt_reg  <= width;
         act_reg  <= 1'b1;
      end else if (busy) begin
         // Each phase lasts width cycles, never under one
         if (cnt_reg > 12'h001) begin
            cnt_reg <= cnt_reg - 12'h001;
         end else begin
            cnt_reg <= width;
            act_reg <= !act_reg && left_reg != 8'h01;
            if (!act_reg) left_reg <= left_reg - 8'h01;
         end
      end
   end
endmodule // pac_pin_source
`default_nettype wire

// File: tb/pulse_accumulator_control_test.sv
// Self-checking bench for the pulse accumulator control block
`timescale 1ns/1ps
`default_nettype none
`define PAC_CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module pulse_accumulator_control_test;
   localparam logic [9:0]  CTL = pac_pkg::PAC_ADDR_CONTROL;
   localparam logic [9:0]  FLG = pac_pkg::PAC_ADDR_FLAGS;
   localparam logic [9:0]  CNT = pac_pkg::PAC_ADDR_COUNT;
   localparam logic [9:0]  SYS = pac_pkg::PAC_ADDR_SYSCTL;
   localparam logic [31:0] ALL = 32'hffff_ffff;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        prescaler_tick = 1'b0, idle_level = 1'b1, start = 1'b0;
   logic [9:0]  paddr = 10'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, r, seed = 32'h0000_0053;
   logic        pready, pslverr, channel7_pin, timer_clock_tick, accum_edge_clock;
   logic        overflow_irq, input_irq, busy, en;
   logic [7:0]  pulses = 8'h01;
   logic [11:0] width = 12'h002;
   logic [15:0] pl;
   logic [1:0]  sel;
   logic [64:0] e;
   logic [64:0] exp_q[$];
   int          bad_count = 0, samples_checked = 0, cycles = 0, ticks = 0, pre = 0, nt;
   pac_accum_control u_pac_accum_control (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .channel7_pin(channel7_pin),
      .prescaler_tick(prescaler_tick), .timer_clock_tick(timer_clock_tick),
      .accum_edge_clock(accum_edge_clock), .overflow_irq(overflow_irq), .input_irq(input_irq));
   pac_pin_source u_pac_pin_source (.pclk(pclk), .presetn(presetn), .idle_level(idle_level),
      .start(start), .pulses(pulses), .width(width), .channel7_pin(channel7_pin), .busy(busy));
   always #12.5 pclk = ~pclk;
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Watchdog, tick counter and read-result monitor
   always @(posedge pclk) begin
      cycles++;
      if (timer_clock_tick === 1'b1) ticks++;
      if (cycles == 20000) begin
         bad_count++;
         complete_run();
      end
      if (psel && penable && !pwrite && pready) begin
         e = exp_q.pop_front();
         `PAC_CHECK({pslverr, prdata & e[63:32]}, {e[64], e[31:0] & e[63:32]})
      end
   end
   task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] m, input logic er, input logic [31:0] d);
      exp_q.push_back({er, m, d});
      apb(1'b0, a, 32'h0000_0000);
   endtask
   // Runs n pin pulses while the prescaler input toggles at random
   task automatic pulse(input logic [7:0] n, input logic [11:0] w);
      @(posedge pclk);
      pulses <= n;
      width  <= w;
      start  <= 1'b1;
      @(posedge pclk);
      start  <= 1'b0;
      pre = 0;
      do begin
         @(posedge pclk);
         r = rnd();
         prescaler_tick <= r[0];
         pre += r[0];
      end while (busy === 1'b1);
      @(posedge pclk);
      prescaler_tick <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(CTL, ALL, 1'b0, 32'h0);
      rd(10'h3fc, ALL, 1'b1, 32'h0);
      apb(1'b1, FLG, 32'hffff_fffc);
      rd(FLG, ALL, 1'b0, 32'h0);
      $display("test reset done");
      idle_level <= 1'b0;
      apb(1'b1, CTL, 32'h51);
      pulse(8'h04, 12'h003);
      rd(CNT, ALL, 1'b0, 32'h4);
      `PAC_CHECK(input_irq, 1'b1)
      apb(1'b1, CTL, 32'h10);
      apb(1'b1, FLG, 32'h1);
      rd(FLG, ALL, 1'b0, 32'h1);
      apb(1'b1, CTL, 32'h51);
      apb(1'b1, FLG, 32'h1);
      rd(FLG, ALL, 1'b0, 32'h0);
      $display("test event done");
      apb(1'b1, CTL, 32'h0);
      idle_level <= 1'b1;
      apb(1'b1, SYS, 32'h1);
      for (int i = 0; i < 5; i++) begin
         r   = rnd();
         pl  = (i == 2) ? 16'h00fe : (i == 3) ? 16'hfffe : {4'h0, r[11:0]};
         sel = (i == 4) ? 2'b01 : 2'(i);
         en  = (i != 4);
         apb(1'b1, CNT, {16'h0, pl});
         apb(1'b1, CTL, {25'h0, en, 2'b00, sel, 2'b11});
         ticks = 0;
         pulse(8'h03, 12'h002);
         nt = (sel == 2'b00 || !en) ? pre : (sel == 2'b01) ? 3 : 1;
         `PAC_CHECK(ticks, nt)
         rd(CNT, ALL, 1'b0, {16'h0, en ? pl + 16'h0003 : pl});
         rd(FLG, ALL, 1'b0, {30'h0, i == 3, en});
         `PAC_CHECK(overflow_irq, i == 3)
         apb(1'b1, FLG, 32'h3);
      end
      $display("test clock select done");
      for (int g = 0; g < 3; g++) begin
         apb(1'b1, CTL, 32'h0);
         apb(1'b1, FLG, 32'h3);
         idle_level <= (g == 1);
         apb(1'b1, SYS, {31'h0, g != 2});
         apb(1'b1, CNT, 32'h0);
         apb(1'b1, CTL, (g == 1) ? 32'h70 : 32'h60);
         pulse(8'h01, 12'd1056);
         rd(CNT, (g == 2) ? ALL : 32'hffff_fffe, 1'b0, (g == 2) ? 32'h0 : 32'h10);
         rd(FLG, ALL, 1'b0, 32'h1);
      end
      $display("test gated done");
      apb(1'b1, SYS, 32'h3);
      rd(CNT, 32'h0, 1'b0, 32'h0);
      rd(FLG, ALL, 1'b0, 32'h0);
      $display("test fast clear done");
      complete_run();
   end
endmodule // pulse_accumulator_control_test
`default_nettype wire
